// >>> pkg/tofrs_pkg.sv
/*
 Shared constants for the time-of-flight frame readout sequencer: array geometry,
 parallel video port byte layout and every timing figure with its cycle count.
 Assumes a 200 MHz system clock on both ends of the link.
*/
`default_nettype none
package tofrs_pkg;
	localparam int CLK_PS = 5000;
	// Array geometry and coordinates
	localparam int COLS = 160;
	localparam int ROWS = 60;
	localparam int ARRAY_COLS = 168;
	localparam int ARRAY_ROWS = 72;
	localparam logic [7:0] COL_FIRST = 8'h04;
	localparam logic [7:0] COL_LAST = 8'ha3;
	localparam logic [7:0] ROW_FIRST = 8'h06;
	localparam logic [7:0] ROW_LAST = 8'h41;
	localparam int PIX_W = 12;
	localparam int WORD_W = 16;
	localparam int SAT_POS = 12;
	// Frame counts per trigger, index by frames_sel
	localparam logic [1:0] FRM_ONE = 2'h0;
	localparam logic [1:0] FRM_TWO = 2'h1;
	localparam logic [1:0] FRM_FOUR = 2'h2;
	// Times in ns as printed
	localparam int T_SHUTTER_NS = 250;
	localparam int T_SHUT_LAG_NS = 18000;
	localparam int T_INT_NS = 1000;
	localparam int T_PROC_NS = 39250;
	localparam int T_CONV12_NS = 31500;
	localparam int T_CONV8_NS = 24500;
	localparam int T_HSYNC_LAG_NS = 17000;
	localparam int T_VSYNC_LAG_NS = 50;
	localparam int T_PCLK_NS = 50;
	// Cycle counts
	localparam int SHUTTER_CYC = (T_SHUTTER_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int SHUT_LAG_CYC = T_SHUT_LAG_NS * 1000 / CLK_PS;
	localparam int INT_CYC = T_INT_NS * 1000 / CLK_PS;
	localparam int PROC_CYC = T_PROC_NS * 1000 / CLK_PS;
	localparam int CONV12_CYC = T_CONV12_NS * 1000 / CLK_PS;
	localparam int CONV8_CYC = T_CONV8_NS * 1000 / CLK_PS;
	localparam int HSYNC_LAG_CYC = T_HSYNC_LAG_NS * 1000 / CLK_PS;
	localparam int VSYNC_LAG_CYC = T_VSYNC_LAG_NS * 1000 / CLK_PS;
	localparam int PCLK_CYC = T_PCLK_NS * 1000 / CLK_PS;
	localparam int PCLK_HALF = PCLK_CYC / 2;
endpackage
`default_nettype wire

// >>> pkg/tofrs_link_if.sv
/*
 Parallel video port between the sensor sequencer and the capture host.
 Assumes each end samples the other's signals on its own clock.
*/
`default_nettype none
interface tofrs_link_if;
	logic shutter_trig; // Measurement start from host
	logic pixel_output_clock; // Pixel clock from device
	logic frame_valid; // Frame strobe
	logic line_valid; // Row burst strobe
	logic [7:0] video_data; // Byte lane
	logic saturation_flag; // Per-pixel saturation
	modport dev(input shutter_trig, output pixel_output_clock, frame_valid, line_valid, video_data, saturation_flag);
	modport host(output shutter_trig, input pixel_output_clock, frame_valid, line_valid, video_data, saturation_flag);
endinterface
`default_nettype wire

// >>> src/tofrs_sync.sv
/*
 Two-flop synchroniser for a group of levels.
 Assumes inputs are asynchronous to clk_sys.
*/
`default_nettype none
module tofrs_sync #(
	parameter int W = 1
) (
	input wire logic clk_sys, // System clock
	input wire logic rst_b, // Async reset, active low
	input wire logic [W-1:0] d_in, // Async levels
	output logic [W-1:0] d_out // Synchronised levels
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			meta_r <= '0;
			d_out <= '0;
		end else begin
			meta_r <= d_in;
			d_out <= meta_r;
		end
	end
endmodule
`default_nettype wire

// >>> src/tofrs_device.sv
/*
 Sensor end: shutter-triggered frame sequencer with row conversion and row output
 on the parallel video port. Pixel charges come from the array model on the user side,
 addressed by coordinates one cycle ahead of the read.
 Assumes the host holds the shutter trigger long enough to be seen.
*/
// Summary of operation
// R1 - Up to 512 frames per second continuously
// R2 - Distance needs four or two phase frames
// R3 - Host holds shutter trigger at least 250ns
// R4 - First illumination pulse 18us after trigger
// R5 - Row conversion 31.5us or 24.5us
// R6 - Line strobe 16us or 8us per row
// R7 - Two-byte formats send pixel over two clocks
// R8 - Frame strobe drops 50ns after last line
// R9 - Frame strobe spans 59 conversions plus output
// R10 - Next frame illumination 17us after last output
// R11 - First output 89.75us or 82.75us after trigger
// R12 - First frame ends 1.964ms or 1.536ms
// R13 - Continuous frame period 60 conversions plus lags
// R14 - Four continuous frames per distance
// R15 - Host stores pixel padded to 16 bits
// R16 - 2x2 groups share integration and readout control
// R17 - Pixel is signed gate difference plus saturation
// R18 - Active coordinates columns 4-163, rows 6-65
// R19 - Rows read bottom to top
// R20 - Even columns converted first, output natural order
// R21 - Frame strobe covers frame, line per row
`default_nettype none
module tofrs_device import tofrs_pkg::*; #(
	parameter int CONV12_N = CONV12_CYC,
	parameter int CONV8_N = CONV8_CYC,
	parameter int PROC_N = PROC_CYC
) (
	input wire logic clk_sys, // System clock
	input wire logic rst_b, // Async reset, active low
	tofrs_link_if.dev link, // Video port
	input wire logic continuous_mode, // Free-running acquisition
	input wire logic res_8bit, // 8-bit conversion and single-byte output
	input wire logic lsb_first, // Split mode byte order
	input wire logic [1:0] frames_sel, // Frames per trigger in single mode
	input wire logic [11:0] storage_gate_a, // Gate A charge of addressed pixel
	input wire logic [11:0] storage_gate_b, // Gate B charge of addressed pixel
	input wire logic pixel_saturated, // Overexposure of addressed pixel
	output logic [7:0] pix_row, // Row coordinate being read
	output logic [7:0] pix_col, // Column coordinate being read
	output logic integ_en, // Integration gates, all four group pixels
	output logic readout_odd, // Odd-column readout pass
	output logic illum_on, // Illumination modulation enable
	output logic busy, // Sequence running
	output logic [1:0] phase_idx // Phase sample frame index
);
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_LAG = 5'b00010,
		ST_INT = 5'b00100,
		ST_PROC = 5'b01000,
		ST_CONV = 5'b10000
	} tofrs_state_t;

	localparam int BEATS_W = 9;

	if (CONV8_N < COLS + 2 || CONV12_N < COLS + 2 || PROC_N < 1) begin : g_chk
		$error("tofrs_device: conversion time too short for one row");
	end

	function automatic logic [7:0] col_of(input logic [7:0] idx);
		col_of = (idx < 8'(COLS / 2)) ? 8'(idx << 1) : 8'(((idx - 8'(COLS / 2)) << 1) | 8'h01);
	endfunction

	tofrs_state_t state_r;
	logic shut_s, shut_d_r, shut_rise;
	logic [13:0] tmr_r;
	logic [5:0] row_r;
	logic [1:0] frm_r;
	logic [7:0] idx_r;
	logic cap_v_r;
	logic [7:0] cap_col_r;
	logic [12:0] conv_buf [COLS];
	logic [12:0] out_buf [COLS];
	logic line_go, line_pend_r, line_last_r, out_last_r;
	logic [3:0] pc_r;
	logic lv_r, fv_r, pclk_r, sat_r;
	logic [7:0] vd_r;
	logic [BEATS_W-1:0] beat_r;
	logic [3:0] vlag_r;
	logic vlag_on_r;
	logic [12:0] diff;
	logic [11:0] pix_val;
	logic pix_sat;
	logic [1:0] frm_max;

	tofrs_sync #(.W(1)) u_shut (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.d_in(link.shutter_trig),
		.d_out(shut_s)
	);

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) shut_d_r <= 1'b0;
		else shut_d_r <= shut_s;
	end
	assign shut_rise = shut_s & ~shut_d_r; // [R3]
	assign frm_max = (frames_sel == FRM_FOUR) ? 2'h3 : ((frames_sel == FRM_TWO) ? 2'h1 : 2'h0); // [R2]
	assign line_go = (state_r == ST_CONV) && (tmr_r == '0);

	// Acquisition sequence
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= ST_IDLE;
			tmr_r <= '0;
			row_r <= '0;
			frm_r <= '0;
		end else begin
			case (state_r)
				ST_IDLE: if (shut_rise) begin
					state_r <= ST_LAG;
					tmr_r <= 14'(SHUT_LAG_CYC - 1); // [R4] [R11] [R12]
					frm_r <= '0;
				end
				ST_LAG: if (tmr_r == '0) begin
					state_r <= ST_INT;
					tmr_r <= 14'(INT_CYC - 1);
				end else tmr_r <= tmr_r - 14'h1;
				ST_INT: if (tmr_r == '0) begin
					state_r <= ST_PROC;
					tmr_r <= 14'(PROC_N - 1);
				end else tmr_r <= tmr_r - 14'h1;
				ST_PROC: if (tmr_r == '0) begin
					state_r <= ST_CONV;
					row_r <= '0;
					tmr_r <= res_8bit ? 14'(CONV8_N - 1) : 14'(CONV12_N - 1); // [R5]
				end else tmr_r <= tmr_r - 14'h1;
				ST_CONV: if (tmr_r == '0) begin
					if (row_r != 6'(ROWS - 1)) begin
						row_r <= row_r + 6'h1;
						tmr_r <= res_8bit ? 14'(CONV8_N - 1) : 14'(CONV12_N - 1); // [R5]
					end else if (continuous_mode || frm_r != frm_max) begin
						state_r <= ST_LAG;
						frm_r <= frm_r + 2'h1; // [R14]
						tmr_r <= 14'(HSYNC_LAG_CYC - 1); // [R10] [R13] [R1]
					end else state_r <= ST_IDLE;
				end else tmr_r <= tmr_r - 14'h1;
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Array control, one strobe for all group pixels
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			integ_en <= 1'b0;
			illum_on <= 1'b0;
			busy <= 1'b0;
			phase_idx <= '0;
		end else begin
			integ_en <= (state_r == ST_INT); // [R16]
			illum_on <= (state_r == ST_INT); // [R4]
			busy <= (state_r != ST_IDLE) || fv_r;
			phase_idx <= frm_r;
		end
	end

	// Row conversion: address then capture one cycle later
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			idx_r <= '0;
			cap_v_r <= 1'b0;
			cap_col_r <= '0;
			pix_row <= ROW_LAST;
			pix_col <= COL_FIRST;
			readout_odd <= 1'b0;
		end else begin
			cap_v_r <= 1'b0;
			if (state_r != ST_CONV || line_go) idx_r <= '0;
			else if (idx_r < 8'(COLS)) begin
				idx_r <= idx_r + 8'h1;
				pix_col <= COL_FIRST + col_of(idx_r); // [R20] [R18]
				pix_row <= ROW_LAST - 8'(row_r); // [R19] [R18]
				readout_odd <= (idx_r >= 8'(COLS / 2)); // [R16]
				cap_v_r <= 1'b1;
				cap_col_r <= col_of(idx_r);
			end
		end
	end

	assign diff = {1'b0, storage_gate_a} - {1'b0, storage_gate_b}; // [R17]
	always_comb begin
		pix_sat = pixel_saturated;
		pix_val = diff[11:0];
		if (diff[12] != diff[11]) begin
			pix_sat = 1'b1;
			pix_val = diff[12] ? 12'h800 : 12'h7ff;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (cap_v_r) conv_buf[cap_col_r] <= {pix_sat, pix_val}; // [R17]
		if (line_go) out_buf <= conv_buf; // [R20]
	end

	// Pixel clock divider, data launched at the falling edge
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pc_r <= '0;
			pclk_r <= 1'b0;
		end else begin
			pc_r <= (pc_r == 4'(PCLK_CYC - 1)) ? 4'h0 : pc_r + 4'h1;
			// Falls one edge after the beat advances, so bytes move exactly with the fall
			pclk_r <= (pc_r < 4'(PCLK_HALF)); // [R7]
		end
	end

	// Row output burst
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			line_pend_r <= 1'b0;
			line_last_r <= 1'b0;
			out_last_r <= 1'b0;
			lv_r <= 1'b0;
			fv_r <= 1'b0;
			beat_r <= '0;
			vd_r <= '0;
			sat_r <= 1'b0;
			vlag_r <= '0;
			vlag_on_r <= 1'b0;
		end else begin
			if (line_go) begin
				line_pend_r <= 1'b1;
				line_last_r <= (row_r == 6'(ROWS - 1));
			end
			if (pc_r == 4'(PCLK_HALF - 1)) begin
				if (lv_r && beat_r != ((res_8bit ? BEATS_W'(COLS) : BEATS_W'(2 * COLS)) - 1'b1)) begin
					beat_r <= beat_r + 1'b1; // [R6] [R7]
				end else if (line_pend_r && !line_go) begin
					line_pend_r <= 1'b0;
					out_last_r <= line_last_r;
					lv_r <= 1'b1; // [R21]
					fv_r <= 1'b1; // [R9] [R21]
					beat_r <= '0;
				end else if (lv_r) begin
					lv_r <= 1'b0;
					vlag_on_r <= out_last_r;
					vlag_r <= 4'(VSYNC_LAG_CYC - 1);
				end
			end
			if (vlag_on_r) begin
				if (vlag_r == '0) begin
					vlag_on_r <= 1'b0;
					fv_r <= 1'b0; // [R8]
				end else vlag_r <= vlag_r - 4'h1;
			end
			if (res_8bit) begin
				vd_r <= out_buf[beat_r[7:0]][11:4];
				sat_r <= out_buf[beat_r[7:0]][SAT_POS];
			end else begin
				sat_r <= out_buf[beat_r[8:1]][SAT_POS];
				if (beat_r[0] ^ lsb_first) vd_r <= {out_buf[beat_r[8:1]][3:0], 3'h0, out_buf[beat_r[8:1]][SAT_POS]}; // [R7]
				else vd_r <= out_buf[beat_r[8:1]][11:4];
			end
		end
	end

	assign link.pixel_output_clock = pclk_r;
	assign link.frame_valid = fv_r;
	assign link.line_valid = lv_r;
	assign link.video_data = vd_r;
	assign link.saturation_flag = sat_r;
endmodule
`default_nettype wire

// >>> src/tofrs_host.sv
/*
 Capture host end: issues shutter pulses and collects the row bursts into
 16-bit pixel words with coordinates.
 Assumes the user side knows the device's resolution and byte order settings.
*/
`default_nettype none
module tofrs_host import tofrs_pkg::*; (
	input wire logic clk_sys, // System clock
	input wire logic rst_b, // Async reset, active low
	tofrs_link_if.host link, // Video port
	input wire logic start_req, // One-cycle request for a shutter pulse
	input wire logic res_8bit, // Single-byte format
	input wire logic lsb_first, // Split mode byte order
	output logic [15:0] pix_word, // Sign data, sat flag at bit 12
	output logic pix_valid, // One-cycle pixel strobe
	output logic [7:0] pix_col, // Column coordinate of pix_word
	output logic [7:0] pix_row, // Row coordinate of pix_word
	output logic frame_done, // One-cycle pulse at frame strobe fall
	output logic shutter_busy // Shutter pulse in progress
);
	logic [11:0] s;
	logic pclk_d_r, lv_d_r, fv_d_r, half_r, shut_r;
	logic [7:0] byte0_r;
	logic [7:0] shut_cnt_r;
	logic pclk_rise;

	tofrs_sync #(.W(12)) u_sync (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.d_in({link.pixel_output_clock, link.frame_valid, link.line_valid, link.saturation_flag, link.video_data}),
		.d_out(s)
	);
	assign pclk_rise = s[11] & ~pclk_d_r;

	// Shutter pulse of fixed least width
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			shut_r <= 1'b0;
			shut_cnt_r <= '0;
		end else if (shut_r) begin
			if (shut_cnt_r == '0) shut_r <= 1'b0;
			else shut_cnt_r <= shut_cnt_r - 8'h1; // [R3]
		end else if (start_req) begin
			shut_r <= 1'b1;
			shut_cnt_r <= 8'(SHUTTER_CYC - 1); // [R3]
		end
	end
	assign link.shutter_trig = shut_r;
	assign shutter_busy = shut_r;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pclk_d_r <= 1'b0;
			lv_d_r <= 1'b0;
			fv_d_r <= 1'b0;
			half_r <= 1'b0;
			byte0_r <= '0;
			pix_word <= '0;
			pix_valid <= 1'b0;
			pix_col <= COL_FIRST;
			pix_row <= ROW_LAST;
			frame_done <= 1'b0;
		end else begin
			pclk_d_r <= s[11];
			pix_valid <= 1'b0;
			frame_done <= pclk_rise & fv_d_r & ~s[10]; // [R21]
			if (pclk_rise) begin
				fv_d_r <= s[10];
				lv_d_r <= s[9];
				if (s[10] && !fv_d_r) pix_row <= ROW_LAST; // [R18]
				if (!s[9] && lv_d_r) pix_row <= pix_row - 8'h1; // [R19]
				if (s[9] && !lv_d_r) begin
					half_r <= 1'b0;
					pix_col <= COL_FIRST - 8'h1;
				end
				if (s[9]) begin
					if (res_8bit) begin
						pix_word <= {3'h0, s[8], s[7:0], 4'h0}; // [R15]
						pix_valid <= 1'b1;
						pix_col <= lv_d_r ? pix_col + 8'h1 : COL_FIRST; // [R20]
					end else if (!half_r) begin
						byte0_r <= s[7:0];
						half_r <= 1'b1;
					end else begin
						half_r <= 1'b0;
						pix_valid <= 1'b1;
						pix_col <= pix_col + 8'h1; // [R20]
						if (lsb_first) pix_word <= {3'h0, s[8], s[7:0], byte0_r[7:4]}; // [R7] [R15]
						else pix_word <= {3'h0, s[8], byte0_r, s[7:4]}; // [R7] [R15]
					end
				end
			end else begin
				fv_d_r <= fv_d_r;
			end
		end
	end
endmodule
`default_nettype wire

// >>> tb/tofrs_link_properties.sv
/*
 Timing properties of the parallel video port between the sensor and host ends.
 Assumes the port signals are sampled on the shared 200 MHz clk_sys.
*/
`default_nettype none
module tofrs_link_properties import tofrs_pkg::*; #(
	parameter int C12 = CONV12_CYC,
	parameter int C8 = CONV8_CYC,
	parameter int PN = PROC_CYC
) (
	input wire logic clk_sys, // System clock
	input wire logic rst_b, // Async reset, active low
	input wire logic shutter_trig, // Shutter from host
	input wire logic pixel_output_clock, // Pixel clock
	input wire logic frame_valid, // Frame strobe
	input wire logic line_valid, // Row strobe
	input wire logic [7:0] video_data, // Byte lane
	input wire logic saturation_flag // Saturation pin
);
	localparam int A12 = SHUT_LAG_CYC + INT_CYC + PN + C12;
	localparam int A8 = SHUT_LAG_CYC + INT_CYC + PN + C8;
	localparam int F12 = 59 * C12 + 2 * COLS * PCLK_CYC + VSYNC_LAG_CYC;
	localparam int F8 = 59 * C8 + COLS * PCLK_CYC + VSYNC_LAG_CYC;
	logic [19:0] lv_hi_r, lv_lo_r, gap_r, fv_hi_r, sh_r;
	logic [7:0] lines_r;
	logic [7:0] sh_hi_r;
	logic armed_r;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			lv_hi_r <= 20'h0;
			lv_lo_r <= 20'h0;
		end else begin
			lv_hi_r <= line_valid ? lv_hi_r + 20'h1 : 20'h0;
			lv_lo_r <= line_valid ? 20'h0 : lv_lo_r + 20'h1;
		end
	end
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			gap_r <= 20'h0;
			lines_r <= 8'h0;
		end else begin
			gap_r <= $rose(line_valid) ? 20'h1 : gap_r + 20'h1;
			if ($rose(line_valid))
				lines_r <= lines_r + 8'h1;
			else if (!frame_valid && !line_valid)
				lines_r <= 8'h0;
		end
	end
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			sh_hi_r <= 8'h0;
		else if (!shutter_trig)
			sh_hi_r <= 8'h0;
		else if (sh_hi_r != 8'hff)
			sh_hi_r <= sh_hi_r + 8'h1;
	end
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			fv_hi_r <= 20'h0;
		else
			fv_hi_r <= frame_valid ? fv_hi_r + 20'h1 : 20'h0;
	end
	// Time from an accepted shutter edge to the first frame strobe
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			armed_r <= 1'b0;
			sh_r <= 20'h0;
		end else if ($rose(shutter_trig) && !armed_r && !frame_valid) begin
			armed_r <= 1'b1;
			sh_r <= 20'h1;
		end else begin
			sh_r <= sh_r + 20'h1;
			if ($rose(frame_valid))
				armed_r <= 1'b0;
		end
	end
	sequence s_clk_high;
		pixel_output_clock [*5] ##1 !pixel_output_clock;
	endsequence
	sequence s_clk_low;
		!pixel_output_clock [*5] ##1 pixel_output_clock;
	endsequence
	AST_PCLK_HIGH: assert property ($rose(pixel_output_clock) |-> s_clk_high)
		else $error("pixel clock high phase wrong");
	AST_PCLK_LOW: assert property ($fell(pixel_output_clock) |-> s_clk_low)
		else $error("pixel clock low phase wrong");
	AST_LINE_LEN: assert property ($fell(line_valid) |-> lv_hi_r == 2 * COLS * PCLK_CYC || lv_hi_r == COLS * PCLK_CYC)
		else $error("line strobe length wrong");
	AST_VSYNC_LAG: assert property ($fell(frame_valid) |-> lv_lo_r == VSYNC_LAG_CYC)
		else $error("frame strobe lag wrong");
	AST_LV_IN_FV: assert property (line_valid |-> frame_valid)
		else $error("line strobe outside frame");
	AST_FV_RISE: assert property ($rose(frame_valid) |-> $rose(line_valid))
		else $error("frame strobe not with first line");
	AST_DATA_EDGE: assert property (line_valid && $changed({video_data, saturation_flag}) |-> $fell(pixel_output_clock))
		else $error("byte changed off pixel clock fall");
	AST_FIRST_OUT: assert property ($rose(frame_valid) && armed_r |->
		(sh_r >= A12 && sh_r <= A12 + 30) || (sh_r >= A8 && sh_r <= A8 + 30))
		else $error("first output delay wrong");
	AST_ROW_GAP: assert property ($rose(line_valid) && $past(frame_valid) |-> gap_r == C12 || gap_r == C8)
		else $error("row spacing wrong");
	AST_FRAME_LEN: assert property ($fell(frame_valid) |-> fv_hi_r == F12 || fv_hi_r == F8)
		else $error("frame strobe length wrong");
	AST_LINE_COUNT: assert property ($fell(frame_valid) |-> lines_r == ROWS)
		else $error("row count per frame wrong");
	AST_SHUT_HOLD: assert property ($fell(shutter_trig) |-> sh_hi_r >= SHUTTER_CYC)
		else $error("shutter pulse too short");
endmodule
`default_nettype wire

// >>> tb/tof_frame_readout_sequencer_tb_top.sv
/*
 Self-checking bench: both link ends face each other, a pixel array model feeds the
 sensor end and a queue model predicts every word the host end collects.
 Assumes the device timing parameters below and a 200 MHz clk_sys.
*/
`default_nettype none
module tof_frame_readout_sequencer_tb_top import tofrs_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int C12 = 3220;
	localparam int C8 = 1620;
	localparam int PN = 10;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic continuous_mode = 1'b0, res_8bit = 1'b0, lsb_first = 1'b0, pixel_saturated = 1'b0, start_req = 1'b0;
	logic [1:0] frames_sel = 2'h0;
	logic [11:0] storage_gate_a = 12'h000, storage_gate_b = 12'h000, ra = 12'h000, rb = 12'h000;
	logic [7:0] d_row, d_col, h_row, h_col;
	logic [15:0] pix_word;
	logic integ_en, readout_odd, illum_on, busy, pix_valid, frame_done, shutter_busy;
	logic [1:0] phase_idx;
	logic [31:0] exp_q[$];
	int n_fail = 0, cmp_count = 0, done_cnt = 0;
	tofrs_link_if link_if();
	tofrs_device #(.CONV12_N(C12), .CONV8_N(C8), .PROC_N(PN)) tofrs_device_inst(.clk_sys(clk_sys),
		.rst_b(rst_b), .link(link_if.dev), .continuous_mode(continuous_mode), .res_8bit(res_8bit),
		.lsb_first(lsb_first), .frames_sel(frames_sel), .storage_gate_a(storage_gate_a),
		.storage_gate_b(storage_gate_b), .pixel_saturated(pixel_saturated), .pix_row(d_row), .pix_col(d_col),
		.integ_en(integ_en), .readout_odd(readout_odd), .illum_on(illum_on), .busy(busy), .phase_idx(phase_idx));
	tofrs_host tofrs_host_inst(.clk_sys(clk_sys), .rst_b(rst_b), .link(link_if.host), .start_req(start_req),
		.res_8bit(res_8bit), .lsb_first(lsb_first), .pix_word(pix_word), .pix_valid(pix_valid), .pix_col(h_col),
		.pix_row(h_row), .frame_done(frame_done), .shutter_busy(shutter_busy));
	tofrs_link_properties #(.C12(C12), .C8(C8), .PN(PN)) tofrs_link_properties_inst(.clk_sys(clk_sys),
		.rst_b(rst_b), .shutter_trig(link_if.shutter_trig), .pixel_output_clock(link_if.pixel_output_clock),
		.frame_valid(link_if.frame_valid), .line_valid(link_if.line_valid), .video_data(link_if.video_data),
		.saturation_flag(link_if.saturation_flag));
	always #2.5 clk_sys = ~clk_sys;
	function automatic logic [11:0] gate_val(logic [7:0] r, logic [7:0] c, logic [11:0] s);
		return 12'(int'(r) * 37 + int'(c) * 11) ^ s;
	endfunction
	function automatic logic sat_val(logic [7:0] r, logic [7:0] c);
		return ((int'(r) + int'(c) + int'(ra[3:0])) % 9) == 0;
	endfunction
	// Word padded to 16 bits, saturation above the data
	function automatic logic [15:0] exp_word(logic [7:0] r, logic [7:0] c);
		int d;
		logic s;
		logic [11:0] x;
		d = int'(gate_val(r, c, ra)) - int'(gate_val(c, r, rb));
		s = sat_val(r, c);
		if (d > 2047) begin
			d = 2047;
			s = 1'b1;
		end else if (d < -2048) begin
			d = -2048;
			s = 1'b1;
		end
		x = 12'(d);
		if (res_8bit)
			x = {x[11:4], 4'h0};
		return {3'h0, s, x};
	endfunction
	// Pixel array answers half a cycle after the coordinates, at the falling edge
	always @(negedge clk_sys) begin
		storage_gate_a <= gate_val(d_row, d_col, ra);
		storage_gate_b <= gate_val(d_col, d_row, rb);
		pixel_saturated <= sat_val(d_row, d_col);
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expv);
		cmp_count++;
		if (seen !== expv) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, expv, seen);
		end
	endtask
	always @(negedge clk_sys) begin : mon
		logic [31:0] e;
		if (frame_done === 1'b1)
			done_cnt++;
		if (pix_valid === 1'b1) begin
			if (exp_q.size() == 0)
				check("extra pixel", 32'h1, 32'h0);
			else begin
				e = exp_q.pop_front();
				check("pixel row", {24'h0, h_row}, {24'h0, e[31:24]});
				check("pixel col", {24'h0, h_col}, {24'h0, e[23:16]});
				check("pixel word", {16'h0, pix_word}, {16'h0, e[15:0]});
			end
		end
	end
	task automatic pulse_start();
		start_req = 1'b1;
		@(negedge clk_sys);
		start_req = 1'b0;
	endtask
	task automatic run(input logic r8, input logic lsb, input logic [1:0] fs, input int nf, input bit retrig);
		int i;
		@(negedge clk_sys);
		res_8bit = r8;
		lsb_first = lsb;
		frames_sel = fs;
		ra = 12'($urandom);
		rb = 12'($urandom);
		done_cnt = 0;
		for (int f = 0; f < nf; f++)
			for (int r = int'(ROW_LAST); r >= int'(ROW_FIRST); r--)
				for (int c = int'(COL_FIRST); c <= int'(COL_LAST); c++)
					exp_q.push_back({8'(r), 8'(c), exp_word(8'(r), 8'(c))});
		pulse_start();
		if (retrig) begin
			repeat (20000) @(negedge clk_sys);
			pulse_start();
		end
		i = 0;
		repeat (100) @(negedge clk_sys);
		while (busy !== 1'b0 && i < 700000) begin
			@(negedge clk_sys);
			i++;
		end
		repeat (50) @(negedge clk_sys);
		check("frames done", 32'(done_cnt), 32'(nf));
		check("pixels left", 32'(exp_q.size()), 32'h0);
		exp_q.delete();
	endtask
	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		void'($urandom(44));
		repeat (3) @(negedge clk_sys);
		rst_b = 1'b1;
		repeat (3) @(negedge clk_sys);
		check("reset row", {24'h0, d_row}, {24'h0, ROW_LAST});
		check("reset col", {24'h0, d_col}, {24'h0, COL_FIRST});
		// Split msb first, with a shutter pulse that must be ignored mid-frame
		run(1'b0, 1'b0, FRM_ONE, 1, 1'b1);
		run(1'b0, 1'b1, 2'h3, 1, 1'b0);
		run(1'b1, 1'b0, FRM_TWO, 2, 1'b0);
		print_verdict();
	end
	initial begin
		repeat (900000) @(posedge clk_sys);
		n_fail++;
		print_verdict();
	end
endmodule
`default_nettype wire
